// File: core/ext_bus_ctrl.sv
// external bus control: selects, strobes, direction, wait, hold and float
// assumes the core holds a request until o_req_ready; pins arrive asynchronous
`default_nettype none
module ext_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter int WAIT_STATES_W = WAIT_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // core access request
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_space,
  input wire logic i_req_write,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_wdata,
  input wire logic [WAIT_STATES_W-1:0] i_req_waits,
  output logic o_req_ready,
  // read data to the core
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic i_rd_ready,
  // external pins
  input wire logic i_ready,
  input wire logic i_hold_req_n,
  input wire logic i_float_n,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_addr_oe,
  output logic o_data_space_sel_n,
  output logic o_program_space_sel_n,
  output logic o_io_space_sel_n,
  output logic o_memory_strobe_n,
  output logic o_io_strobe_n,
  output logic o_read_write,
  output logic o_ctrl_oe,
  output logic o_bus_release_ack_n,
  output logic o_wait_state_marker_n,
  output logic o_marker_oe
);
  // refuse a wait count that cannot reach the ready threshold
  if (WAIT_STATES_W < 2) begin : g_bad_width
    $error("wait count too narrow for ready detection");
  end

  bus_state_t state, next_state;
  logic [1:0] ready_sync, hold_sync, float_sync;
  logic [DATA_W-1:0] data_s1, data_s2;
  logic [WAIT_STATES_W-1:0] wait_cnt, waits;
  logic [1:0] space;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic buf_ready, cap_valid;
  logic [1:0] rd_pend;

  // two-flop synchronisers on all pin inputs
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ready_sync <= 2'h3;
      hold_sync <= 2'h3;
      float_sync <= 2'h3;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      ready_sync <= {ready_sync[0], i_ready};
      hold_sync <= {hold_sync[0], i_hold_req_n};
      float_sync <= {float_sync[0], i_float_n};
      data_s1 <= i_data;
      data_s2 <= data_s1;
    end
  end
  wire ready_s = ready_sync[1];
  wire hold_s = ~hold_sync[1]; // R9
  wire float_s = ~float_sync[1];

  // sequencing decisions
  wire active = (state == ST_WAIT) || (state == ST_READY) || (state == ST_DONE);
  wire use_ready = (waits >= WAIT_STATES_W'(READY_WAIT_MIN)); // R7
  wire waits_done = (wait_cnt == '0); // R8
  // no new access while a read word is still on its way into the buffer
  wire take = (state == ST_IDLE) && i_req_valid && !hold_s && buf_ready
    && (rd_pend == 2'h0);
  wire finish_read = (state == ST_DONE) && !write;
  wire last_wait = (state == ST_WAIT) && (wait_cnt == WAIT_STATES_W'(1));
  wire next_marker_n = !(take && (i_req_waits >= WAIT_STATES_W'(READY_WAIT_MIN)))
    && !((state == ST_WAIT) && !o_wait_state_marker_n && !last_wait); // R14

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (hold_s) next_state = ST_HOLD;
        else if (take) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (waits_done) next_state = use_ready ? ST_READY : ST_DONE;
      end
      ST_READY: begin
        if (ready_s) next_state = ST_DONE; // R6
      end
      ST_DONE: next_state = ST_IDLE;
      ST_HOLD: begin
        if (!hold_s) next_state = ST_RESUME;
      end
      ST_RESUME: next_state = ST_IDLE; // R17
    endcase
  end
  wire next_wait = (state == ST_WAIT) && !waits_done;

  // access capture and state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_IDLE;
      wait_cnt <= '0;
      waits <= '0;
      space <= 2'h0;
      write <= 1'b0;
      addr <= '0;
      wdata <= '0;
      rd_pend <= 2'h0;
    end else begin
      state <= next_state;
      rd_pend <= {rd_pend[0], finish_read};
      if (take) begin
        wait_cnt <= i_req_waits;
        waits <= i_req_waits;
        space <= i_req_space;
        write <= i_req_write;
        addr <= (i_req_space == SPACE_PROG) ? i_req_addr
          : {{(ADDR_W-LOW_ADDR_W){1'b0}}, i_req_addr[LOW_ADDR_W-1:0]}; // R15
        wdata <= i_req_wdata;
      end else if (next_wait) begin
        wait_cnt <= wait_cnt - WAIT_STATES_W'(1);
      end
    end
  end

  // registered pin outputs
  wire next_act = (next_state == ST_WAIT) || (next_state == ST_READY)
    || (next_state == ST_DONE);
  wire [1:0] next_space = take ? i_req_space : space;
  wire next_wr = take ? i_req_write : write;
  wire next_hold = (next_state == ST_HOLD);
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data_space_sel_n <= 1'b1;
      o_program_space_sel_n <= 1'b1;
      o_io_space_sel_n <= 1'b1;
      o_memory_strobe_n <= 1'b1;
      o_io_strobe_n <= 1'b1;
      o_read_write <= 1'b1;
      o_ctrl_oe <= 1'b0;
      o_addr_oe <= 1'b0;
      o_data_oe <= 1'b0;
      o_data <= '0;
      o_addr <= '0;
      o_bus_release_ack_n <= 1'b1;
      o_wait_state_marker_n <= 1'b1;
      o_marker_oe <= 1'b0;
      o_req_ready <= 1'b0;
    end else begin
      o_data_space_sel_n <= !(next_act && next_space == SPACE_DATA); // R1 R2
      o_program_space_sel_n <= !(next_act && next_space == SPACE_PROG); // R1 R2
      o_io_space_sel_n <= !(next_act && next_space == SPACE_IO); // R1 R2
      o_memory_strobe_n <= !(next_act && next_space != SPACE_IO); // R3
      o_io_strobe_n <= !(next_act && next_space == SPACE_IO); // R4
      o_read_write <= !(next_act && next_wr); // R5
      o_ctrl_oe <= !next_hold && !float_s; // R10 R11 R12
      o_addr_oe <= !next_hold && !float_s; // R10
      o_data_oe <= next_act && next_wr && !next_hold && !float_s; // R16
      o_data <= take ? i_req_wdata : wdata;
      o_addr <= take ? (i_req_space == SPACE_PROG ? i_req_addr
        : {{(ADDR_W-LOW_ADDR_W){1'b0}}, i_req_addr[LOW_ADDR_W-1:0]}) : addr;
      o_bus_release_ack_n <= !next_hold; // R13
      o_wait_state_marker_n <= next_marker_n; // R14
      o_marker_oe <= !float_s;
      o_req_ready <= take;
    end
  end

  // word sampled at the done edge leaves the second data flop two edges later
  assign cap_valid = rd_pend[1];
  ext_bus_skid #(.WIDTH(DATA_W)) u_skid (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_valid(cap_valid),
    .i_data(data_s2),
    .o_ready(buf_ready),
    .o_valid(o_rd_valid),
    .o_data(o_rd_data),
    .i_ready(i_rd_ready)
  );

  // checks
  sequence hold_seen_s;
    hold_s && state == ST_IDLE;
  endsequence
  property hold_float_p;
    @(posedge i_clk) disable iff (i_reset) hold_seen_s |=> !o_ctrl_oe && !o_bus_release_ack_n;
  endproperty
  hold_float_a: assert property (hold_float_p) else $error("hold did not float"); // R10 R11 R13
  float_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    float_s |=> !o_ctrl_oe) else $error("float ignored"); // R12
  one_select_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $countones({o_data_space_sel_n, o_program_space_sel_n, o_io_space_sel_n}) >= 2)
    else $error("two selects low"); // R1
  select_active_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_data_space_sel_n && o_program_space_sel_n && o_io_space_sel_n) == !active)
    else $error("select not aligned with access"); // R2
  mem_strobe_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_memory_strobe_n |-> o_io_space_sel_n && active) else $error("bad mem strobe"); // R3
  io_strobe_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_io_strobe_n |-> !o_io_space_sel_n) else $error("bad io strobe"); // R4
  write_dir_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_read_write |-> active && write) else $error("write outside access"); // R5
  ready_wait_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state == ST_READY && !ready_s |=> state == ST_READY) else $error("ready ignored"); // R6
  ready_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state == ST_READY |-> use_ready) else $error("ready sampled early"); // R7
  data_float_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_data_oe |-> o_bus_release_ack_n && !o_read_write) else $error("data driven"); // R16
  resume_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state == ST_HOLD && !hold_s |=> state == ST_RESUME ##1 state == ST_IDLE)
    else $error("no idle after hold"); // R17
endmodule
`default_nettype wire

// File: pkg/ext_bus_pkg.sv
// constants and types for the external bus control block
// assumes one 100 MHz clock and the core issuing one access at a time
// Behaviour
// R1 - space selects idle high; only the accessed space's select goes low
// R2 - select low interval matches the valid-address interval
// R3 - memory strobe low only during external data or program access
// R4 - io strobe low only during external io access
// R5 - read/write line high, low only during an external write
// R6 - ready low means wait one cycle and sample again
// R7 - ready is sampled only with two or more software wait states
// R8 - ready is not sampled before software wait states complete
// R9 - an outside master asserts hold request to take the bus
// R10 - on hold acknowledge, address, data and control float
// R11 - in hold, selects, strobes and read/write float
// R12 - float input low floats selects and both strobes always
// R13 - hold acknowledge shows the bus has been released
// R14 - wait marker low from first wait state until start of last
// R15 - low sixteen address lines always; upper seven only for program space
// R16 - data bus floats unless writing, and during reset or hold
// R17 - after hold ends, control lines return idle before a new access
`default_nettype none
package ext_bus_pkg;
  localparam int ADDR_W = 23;
  localparam int LOW_ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int WAIT_W = 3;
  localparam int READY_WAIT_MIN = 2;
  // which external space an access targets
  typedef enum logic [1:0] {SPACE_DATA, SPACE_PROG, SPACE_IO} space_t;
  // bus sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_READY, ST_DONE, ST_HOLD, ST_RESUME} bus_state_t;
endpackage
`default_nettype wire

// File: core/ext_bus_skid.sv
// two-entry buffer carrying read data from the bus to the core
// assumes one clock; source and sink follow valid/ready
`default_nettype none
module ext_bus_skid
  import ext_bus_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  // refuse an empty word
  if (WIDTH < 1) begin : g_bad_width
    $error("buffer width must be at least one bit");
  end
  logic [WIDTH-1:0] spare;
  logic spare_valid;
  // output word plus one spare, so a stalled sink loses nothing
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_valid <= 1'b0;
      o_data <= '0;
      spare_valid <= 1'b0;
      spare <= '0;
    end else if (spare_valid) begin
      if (i_ready) begin
        o_data <= spare;
        spare_valid <= 1'b0;
      end
    end else if (!o_valid || i_ready) begin
      o_valid <= i_valid;
      if (i_valid) o_data <= i_data;
    end else if (i_valid) begin
      spare <= i_data;
      spare_valid <= 1'b1;
    end
  end
  // room while the spare is empty; outputs come straight from flops
  assign o_ready = !spare_valid;
endmodule
`default_nettype wire

// File: tb/ext_mem_model.sv
// external memory and io device model facing the bus control pins
// assumes reads return address xor 5a5a; ready low for i_slow cycles
`default_nettype none
module ext_mem_model (
  // clock
  input wire logic i_clk,
  // control pins from the block
  input wire logic i_mem_strobe_n,
  input wire logic i_io_strobe_n,
  input wire logic i_read_write,
  input wire logic [15:0] i_addr,
  input wire logic [3:0] i_slow,
  // answer pins
  output logic o_ready,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy_cnt = 4'h0;
  logic [15:0] last = 16'h0;
  wire logic active = !(i_mem_strobe_n && i_io_strobe_n);
  wire logic reading = active && i_read_write;
  // ready held low while the slow device is busy
  assign o_ready = !(active && busy_cnt < i_slow);
  // read word while a strobe is low with read/write high, otherwise a pattern changing every cycle
  assign o_data = reading ? (i_addr ^ 16'h5a5a) : ~last;
  // busy counter per access and last driven value
  always_ff @(posedge i_clk) begin
    busy_cnt <= active ? busy_cnt + {3'h0, busy_cnt != 4'hf} : 4'h0;
    last <= o_data;
  end
endmodule
`default_nettype wire

// File: tb/external_bus_control_test.sv
// testbench for the external bus controller: spaces, waits, stall, hold, float
// assumes ext_mem_model answers reads; inputs change at the falling edge
`default_nettype none
module external_bus_control_test
  import ext_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_reset, i_req_valid, i_req_write, o_req_ready, o_rd_valid, i_rd_ready;
  logic i_ready, i_hold_req_n, i_float_n, o_data_oe, o_addr_oe, o_data_space_sel_n;
  logic o_program_space_sel_n, o_io_space_sel_n, o_memory_strobe_n, o_io_strobe_n;
  logic o_read_write, o_ctrl_oe, o_bus_release_ack_n, o_wait_state_marker_n, o_marker_oe;
  logic [1:0] i_req_space;
  logic [ADDR_W-1:0] i_req_addr, o_addr;
  logic [DATA_W-1:0] i_req_wdata, o_rd_data, i_data, o_data;
  logic [WAIT_W-1:0] i_req_waits;
  logic [3:0] slow;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  ext_bus_ctrl i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .i_req_space(i_req_space), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_req_waits(i_req_waits), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready),
    .i_ready(i_ready), .i_hold_req_n(i_hold_req_n), .i_float_n(i_float_n), .i_data(i_data),
    .o_data(o_data), .o_data_oe(o_data_oe), .o_addr(o_addr), .o_addr_oe(o_addr_oe),
    .o_data_space_sel_n(o_data_space_sel_n), .o_program_space_sel_n(o_program_space_sel_n),
    .o_io_space_sel_n(o_io_space_sel_n), .o_memory_strobe_n(o_memory_strobe_n),
    .o_io_strobe_n(o_io_strobe_n), .o_read_write(o_read_write), .o_ctrl_oe(o_ctrl_oe),
    .o_bus_release_ack_n(o_bus_release_ack_n), .o_wait_state_marker_n(o_wait_state_marker_n),
    .o_marker_oe(o_marker_oe));
  ext_mem_model i_mem (.i_clk(i_clk), .i_mem_strobe_n(o_memory_strobe_n),
    .i_io_strobe_n(o_io_strobe_n), .i_read_write(o_read_write), .i_addr(o_addr[15:0]),
    .i_slow(slow), .o_ready(i_ready), .o_data(i_data));
  // clock and hang guard
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one access; len returns cycles with a select low
  task access(input logic [1:0] sp, input logic wr, input logic [22:0] ad,
              input logic [2:0] w, input logic [3:0] sl, output int len);
    int n;
    n = 0;
    len = 0;
    slow = sl;
    i_req_valid = 1;
    i_req_space = sp;
    i_req_write = wr;
    i_req_addr = ad;
    i_req_waits = w;
    i_req_wdata = ~ad[15:0];
    while (o_req_ready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    i_req_valid = 0;
    chk("data sel", sp != 2'd0, o_data_space_sel_n);
    chk("prog sel", sp != 2'd1, o_program_space_sel_n);
    chk("io sel", sp != 2'd2, o_io_space_sel_n);
    chk("mem strobe", sp == 2'd2, o_memory_strobe_n);
    chk("io strobe", sp != 2'd2, o_io_strobe_n);
    chk("rw", !wr, o_read_write);
    chk("addr high", sp == 2'd1 ? ad[22:16] : 7'h0, o_addr[22:16]);
    chk("marker", w < 3'd2, o_wait_state_marker_n);
    if (wr) chk("wdata", {1'b1, ~ad[15:0]}, {o_data_oe, o_data});
    while (!(o_data_space_sel_n & o_program_space_sel_n & o_io_space_sel_n) && len < 60) begin
      chk("addr held", ad[15:0], o_addr[15:0]);
      @(negedge i_clk);
      len++;
    end
    chk("data float", 0, o_data_oe);
    n = 0;
    if (!wr && i_rd_ready) begin
      while (o_rd_valid !== 1'b1 && n < 10) begin
        @(negedge i_clk);
        n++;
      end
      chk("rdata", ad[15:0] ^ 16'h5a5a, o_rd_data);
    end
    @(negedge i_clk);
  endtask
  task t_spaces;
    int len;
    for (int s = 0; s < 3; s++) begin
      for (int w = 0; w < 2; w++) begin
        access(s[1:0], w[0], 23'h7abcd0 + s, 0, 0, len);
        chk("len w0", 2, len);
      end
    end
  endtask
  task t_waits;
    int len, len0;
    access(0, 0, 23'h00123, 1, 8, len);
    chk("len w1 ready ignored", 3, len);
    access(1, 0, 23'h45678, 3, 0, len0);
    chk("len w3", 6, len0);
    access(1, 0, 23'h45679, 3, 1, len);
    chk("ready not early", len0, len);
    access(0, 0, 23'h0abcd, 2, 8, len);
    chk("len slow", 1, len >= 9 && len <= 14);
  endtask
  task t_stall;
    int len, n, k;
    i_rd_ready = 0;
    access(0, 0, 23'h00010, 0, 0, len);
    access(0, 0, 23'h00011, 0, 0, len);
    i_req_valid = 1;
    i_req_addr = 23'h00012;
    n = 0;
    repeat (20) @(negedge i_clk) if (o_req_ready === 1'b1) n++;
    chk("full refused", 0, n);
    i_rd_ready = 1;
    k = 0;
    repeat (60) begin
      if (o_req_ready === 1'b1) i_req_valid = 0;
      if (o_rd_valid === 1'b1) begin
        chk("stall data", (16'h0010 + k) ^ 16'h5a5a, o_rd_data);
        k++;
      end
      @(negedge i_clk);
    end
    chk("stall words", 3, k);
  endtask
  task t_hold_float;
    int n, len;
    i_hold_req_n = 0;
    n = 0;
    while (o_bus_release_ack_n !== 1'b0 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("hold ack", 0, o_bus_release_ack_n);
    chk("hold float", 0, {o_ctrl_oe, o_addr_oe, o_data_oe});
    i_hold_req_n = 1;
    n = 0;
    while (o_bus_release_ack_n !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk("resume", 5'h1f, {o_ctrl_oe, o_data_space_sel_n, o_program_space_sel_n,
      o_io_space_sel_n, o_read_write});
    access(2, 1, 23'h00077, 0, 0, len);
    i_float_n = 0;
    repeat (4) @(negedge i_clk);
    chk("float", 0, {o_ctrl_oe, o_addr_oe, o_marker_oe});
    i_float_n = 1;
    repeat (4) @(negedge i_clk);
    chk("unfloat", 3'h7, {o_ctrl_oe, o_addr_oe, o_marker_oe});
  endtask
  // reset, then the scenarios in turn
  initial begin
    i_reset = 1;
    {i_req_valid, i_req_write, i_req_space, i_req_addr, i_req_wdata, i_req_waits} = '0;
    {i_rd_ready, i_hold_req_n, i_float_n} = 3'h7;
    slow = 4'h0;
    repeat (8) @(negedge i_clk);
    i_reset = 0;
    @(negedge i_clk);
    t_spaces();
    t_waits();
    t_stall();
    t_hold_float();
    results();
  end
endmodule
`default_nettype wire
